//--- aclri_pkg.sv
// Shared constants and types for the rule-table indirect access path
package aclri_pkg;

    // Directly addressed registers of the device
    localparam logic [7:0] ACL_SEL_ADDR = 8'h6e;
    localparam logic [7:0] ACL_OFS_ADDR = 8'h6f;
    localparam logic [7:0] ACL_DATA_ADDR = 8'ha0;

    // Fields of the select control byte
    localparam int SEL_DIR_BIT = 4;
    localparam int SEL_TBL_LSB = 5;
    localparam logic [2:0] SEL_TBL_RULE = 3'h2;
    localparam logic [7:0] SEL_RESET = 8'h00;
    localparam logic [7:0] OFS_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // Table geometry
    localparam int NUM_PORTS = 5;
    localparam int NUM_ENTRIES = 16;
    localparam logic [3:0] FIRST_PORT = 4'h1;
    localparam logic [3:0] LAST_PORT = 4'h5;

    // Offsets inside one port table
    localparam logic [7:0] OFS_FRN_BYTE = 8'h00;
    localparam logic [7:0] OFS_MODE_BYTE = 8'h01;
    localparam logic [7:0] OFS_SET_LO = 8'h0c;
    localparam logic [7:0] OFS_SET_HI = 8'h0d;
    localparam logic [7:0] OFS_RSVD_A = 8'h0e;
    localparam logic [7:0] OFS_RSVD_B = 8'h0f;
    localparam logic [7:0] OFS_BEN_HI = 8'h10;
    localparam logic [7:0] OFS_BEN_LO = 8'h11;
    localparam logic [7:0] OFS_CTRL = 8'h12;
    localparam logic [3:0] ENTRY_TOP_BYTE = 4'hf;

    // Field positions and reset values of the entry bytes
    localparam int FRN_LSB = 0;
    localparam int MODE_LSB = 4;
    localparam logic [3:0] FRN_RESET = 4'h0;
    localparam logic [15:0] BEN_RESET = 16'hffff;
    localparam logic [3:0] ENTRY_SEL_RESET = 4'h0;
    localparam int CTRL_VALID_BIT = 7;

    typedef enum logic [1:0] {
        MODE_OFF = 2'h0,
        MODE_L2 = 2'h1,
        MODE_L3 = 2'h2,
        MODE_L4 = 2'h3
    } aclri_mode_t;

    // Host-side Avalon registers, byte addresses
    localparam logic [3:0] HOST_CMD_ADDR = 4'h0;
    localparam logic [3:0] HOST_STAT_ADDR = 4'h4;
    localparam int CMD_PORT_LSB = 0;
    localparam int CMD_READ_BIT = 4;
    localparam int CMD_ENTRY_LSB = 8;
    localparam int CMD_OFS_LSB = 16;
    localparam int CMD_DATA_LSB = 24;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_ERR_BIT = 2;
    localparam int STAT_BYTE_LSB = 8;

    typedef enum logic [1:0] {
        STEP_WR,
        STEP_RD_CHECK,
        STEP_RD_DATA,
        STEP_END
    } aclri_step_t;

endpackage

//--- aclri_link_if.sv
// Byte register link between the host controller and the device
`timescale 1ns/1ps
interface aclri_link_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic rvalid;

    modport dev (
        input addr,
        input wdata,
        input wr,
        input rd,
        output rdata,
        output rvalid
    );

    modport host (
        output addr,
        output wdata,
        output wr,
        output rd,
        input rdata,
        input rvalid
    );
endinterface

//--- aclri_device.sv
// Device end: indirect access to the per-port rule tables
`timescale 1ns/1ps
// Behaviour
// [R1] Host updates entries by read-modify-write; this host writes single bytes and leaves that to software
// [R2] Entry read: two control writes, two reads; the host issues three reads (select, offset, data byte)
// [R3] Entry write: one control read, three writes
// [R4] Select low nibble gives port, address 11:8
// [R5] Offset byte gives indirect address 7:0
// [R6] Offsets 0x00-0x0d map bytes fifteen downward
// [R7] Offsets 0x0e, 0x0f reserved, no content
// [R8] Offsets 0x10, 0x11 hold byte-enable masks
// [R9] Offset 0x12 is entry control and status
// [R10] Select bits 7:5 = 010 picks rule table
// [R11] Data byte register carries the addressed byte
// [R12] Sixteen entries per port, first rule field
// [R13] First rule field names the applied action
// [R14] Offsets 0x0c, 0x0d combine rules into sets; this device reads them as zero and drops writes
// [R15] Mode field: off, layer 2, 3, 4
// [R16] Select bit 4: one read, zero write
// [R17] Offset write triggers; read fills data byte
// [R18] Reserved bits read zero, ignore writes
module aclri_device
    import aclri_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register link
    aclri_link_if.dev link,
    // Rule lookup by the matching logic
    input wire logic [3:0] lookup_port,
    input wire logic [3:0] lookup_entry,
    output logic [3:0] lookup_action_entry,
    output aclri_pkg::aclri_mode_t lookup_mode,
    output logic lookup_active
);
    import aclri_pkg::*;

    typedef struct packed {
        logic [7:0] sel;
        logic [7:0] ofs;
        logic [7:0] data;
        logic [NUM_PORTS-1:0][NUM_ENTRIES-1:0][3:0] frn;
        logic [NUM_PORTS-1:0][NUM_ENTRIES-1:0][1:0] mode;
        logic [NUM_PORTS-1:0][15:0] ben;
        logic [NUM_PORTS-1:0][3:0] entry_sel;
        logic [7:0] rdata;
        logic rvalid;
        logic [3:0] act;
        logic [1:0] lmode;
        logic lact;
    } aclri_dev_st_t;

    aclri_dev_st_t st_ff;
    aclri_dev_st_t nxt_st;

    logic acl_hit;
    logic [2:0] pidx;
    logic [3:0] eidx;
    logic dir_read;
    logic [3:0] byte_no;
    logic [7:0] fetched;
    logic lk_ok;
    logic [2:0] lk_pidx;

    // Table select and port decode
    always_comb begin
        acl_hit = (st_ff.sel[7:SEL_TBL_LSB] == SEL_TBL_RULE) // [R10]
            && (st_ff.sel[3:0] >= FIRST_PORT)
            && (st_ff.sel[3:0] <= LAST_PORT);
        pidx = 3'(st_ff.sel[3:0] - FIRST_PORT); // [R4]
        dir_read = st_ff.sel[SEL_DIR_BIT]; // [R16]
        eidx = acl_hit ? st_ff.entry_sel[pidx] : 4'h0;
        byte_no = ENTRY_TOP_BYTE - st_ff.ofs[3:0]; // [R6]
    end

    // Byte fetched from the indirect location for a given offset
    function automatic logic [7:0] fetch_byte(
        input aclri_dev_st_t s,
        input logic [2:0] p,
        input logic [3:0] e,
        input logic [7:0] ofs
    );
        logic [7:0] b;
        b = 8'h00;
        unique case (ofs) // [R5]
            OFS_FRN_BYTE: b[FRN_LSB +: 4] = s.frn[p][e]; // [R12] [R18]
            OFS_MODE_BYTE: b[MODE_LSB +: 2] = s.mode[p][e]; // [R15] [R18]
            OFS_BEN_HI: b = s.ben[p][15:8]; // [R8]
            OFS_BEN_LO: b = s.ben[p][7:0]; // [R8]
            OFS_CTRL: begin
                b[3:0] = s.entry_sel[p]; // [R9]
                b[CTRL_VALID_BIT] = 1'b1;
            end
            // Set-combining, compare and action bytes live in the matching engine
            default: b = 8'h00; // [R7] [R14]
        endcase
        return b;
    endfunction

    assign fetched = fetch_byte(st_ff, pidx, eidx, link.wdata);

    // Lookup port decode for the matching logic
    always_comb begin
        lk_ok = (lookup_port >= FIRST_PORT) && (lookup_port <= LAST_PORT);
        lk_pidx = 3'(lookup_port - FIRST_PORT);
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rvalid = 1'b0;

        // Direct register writes
        if (link.wr) begin
            unique case (link.addr)
                ACL_SEL_ADDR: nxt_st.sel = link.wdata;
                ACL_OFS_ADDR: begin
                    nxt_st.ofs = link.wdata;
                    // Read trigger loads the data byte from the new offset
                    if (acl_hit && dir_read) begin // [R17]
                        nxt_st.data = fetched; // [R11]
                    end
                end
                ACL_DATA_ADDR: begin
                    nxt_st.data = link.wdata;
                    // Commit only for the rule table in write direction
                    if (acl_hit && !dir_read) begin // [R11] [R16]
                        unique case (st_ff.ofs)
                            OFS_FRN_BYTE: begin
                                if (st_ff.ben[pidx][byte_no]) begin // [R8]
                                    nxt_st.frn[pidx][eidx] = link.wdata[FRN_LSB +: 4]; // [R12]
                                end
                            end
                            OFS_MODE_BYTE: begin
                                if (st_ff.ben[pidx][byte_no]) begin // [R8]
                                    nxt_st.mode[pidx][eidx] = link.wdata[MODE_LSB +: 2]; // [R15]
                                end
                            end
                            OFS_BEN_HI: nxt_st.ben[pidx][15:8] = link.wdata; // [R8]
                            OFS_BEN_LO: nxt_st.ben[pidx][7:0] = link.wdata; // [R8]
                            OFS_CTRL: nxt_st.entry_sel[pidx] = link.wdata[3:0]; // [R9]
                            // Reserved and unheld bytes drop the write
                            default: nxt_st.ben = st_ff.ben; // [R7] [R18]
                        endcase
                    end
                end
                default: nxt_st.sel = st_ff.sel;
            endcase
        end

        // Direct register reads answer one cycle later
        if (link.rd) begin
            nxt_st.rvalid = 1'b1;
            unique case (link.addr)
                ACL_SEL_ADDR: nxt_st.rdata = st_ff.sel;
                ACL_OFS_ADDR: nxt_st.rdata = st_ff.ofs;
                ACL_DATA_ADDR: nxt_st.rdata = st_ff.data; // [R11]
                default: nxt_st.rdata = 8'h00;
            endcase
        end

        // The first rule field picks whose action applies on a match
        if (lk_ok) begin
            nxt_st.act = st_ff.frn[lk_pidx][lookup_entry]; // [R13]
            nxt_st.lmode = st_ff.mode[lk_pidx][lookup_entry]; // [R15]
            nxt_st.lact = (st_ff.mode[lk_pidx][lookup_entry] != MODE_OFF); // [R15]
        end else begin
            nxt_st.act = 4'h0;
            nxt_st.lmode = MODE_OFF;
            nxt_st.lact = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff.sel <= SEL_RESET;
            st_ff.ofs <= OFS_RESET;
            st_ff.data <= DATA_RESET;
            st_ff.frn <= '0;
            st_ff.mode <= '0;
            st_ff.ben <= {NUM_PORTS{BEN_RESET}};
            st_ff.entry_sel <= {NUM_PORTS{ENTRY_SEL_RESET}};
            st_ff.rdata <= 8'h00;
            st_ff.rvalid <= 1'b0;
            st_ff.act <= 4'h0;
            st_ff.lmode <= MODE_OFF;
            st_ff.lact <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign link.rdata = st_ff.rdata;
    assign link.rvalid = st_ff.rvalid;
    assign lookup_action_entry = st_ff.act;
    assign lookup_mode = aclri_mode_t'(st_ff.lmode);
    assign lookup_active = st_ff.lact;

endmodule

//--- aclri_host.sv
// Host end: Avalon-MM command registers driving the indirect access sequences
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ps
module aclri_host
    import aclri_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Register link
    aclri_link_if.host link
);
    import aclri_pkg::*;

    typedef enum logic [1:0] {
        H_IDLE,
        H_ISSUE,
        H_WAIT
    } aclri_hstate_t;

    typedef struct packed {
        aclri_hstate_t state;
        logic [31:0] cmd;
        logic [3:0] step;
        logic [7:0] rbyte;
        logic done;
        logic err;
        logic wait_n;
        logic [31:0] rdata;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } aclri_host_st_t;

    aclri_host_st_t st_ff;
    aclri_host_st_t nxt_st;

    logic [17:0] cur;
    aclri_step_t cur_kind;
    logic [7:0] cur_addr;
    logic [7:0] cur_data;
    logic set_done;
    logic set_err;

    // One step of the sequence: kind, address, data or expected value
    function automatic logic [17:0] step_of(input logic [31:0] c, input logic [3:0] i);
        logic [7:0] selw;
        logic [7:0] selr;
        logic [7:0] ofs;
        selw = {SEL_TBL_RULE, 1'b0, c[CMD_PORT_LSB +: 4]}; // [R10] [R16]
        selr = {SEL_TBL_RULE, 1'b1, c[CMD_PORT_LSB +: 4]}; // [R16]
        ofs = c[CMD_OFS_LSB +: 8];
        step_of = {STEP_END, 16'h0000};
        // Entry select through the control offset comes first
        unique case (i)
            4'h0: step_of = {STEP_WR, ACL_SEL_ADDR, selw};
            4'h1: step_of = {STEP_WR, ACL_OFS_ADDR, OFS_CTRL};
            4'h2: step_of = {STEP_WR, ACL_DATA_ADDR, 4'h0, c[CMD_ENTRY_LSB +: 4]};
            default: step_of = {STEP_END, 16'h0000};
        endcase
        if (c[CMD_READ_BIT]) begin
            unique case (i) // [R2]
                4'h3: step_of = {STEP_WR, ACL_SEL_ADDR, selr};
                4'h4: step_of = {STEP_WR, ACL_OFS_ADDR, ofs}; // [R17]
                4'h5: step_of = {STEP_RD_CHECK, ACL_SEL_ADDR, selr};
                4'h6: step_of = {STEP_RD_CHECK, ACL_OFS_ADDR, ofs};
                4'h7: step_of = {STEP_RD_DATA, ACL_DATA_ADDR, 8'h00};
                default: step_of = step_of;
            endcase
        end else begin
            unique case (i) // [R3]
                4'h3: step_of = {STEP_WR, ACL_OFS_ADDR, ofs};
                4'h4: step_of = {STEP_RD_CHECK, ACL_SEL_ADDR, selw};
                4'h5: step_of = {STEP_WR, ACL_DATA_ADDR, c[CMD_DATA_LSB +: 8]};
                default: step_of = step_of;
            endcase
        end
    endfunction

    always_comb begin
        cur = step_of(st_ff.cmd, st_ff.step);
        cur_kind = aclri_step_t'(cur[17:16]);
        cur_addr = cur[15:8];
        cur_data = cur[7:0];
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.wr = 1'b0;
        nxt_st.rd = 1'b0;
        nxt_st.wait_n = 1'b0;
        set_done = 1'b0;
        set_err = 1'b0;

        unique case (st_ff.state)
            H_IDLE: nxt_st.step = 4'h0;
            H_ISSUE: begin
                nxt_st.addr = cur_addr;
                unique case (cur_kind)
                    STEP_WR: begin
                        nxt_st.wr = 1'b1;
                        nxt_st.wdata = cur_data;
                        nxt_st.step = st_ff.step + 4'h1;
                    end
                    STEP_RD_CHECK, STEP_RD_DATA: begin
                        nxt_st.rd = 1'b1;
                        nxt_st.state = H_WAIT;
                    end
                    STEP_END: begin
                        set_done = 1'b1;
                        nxt_st.state = H_IDLE;
                    end
                endcase
            end
            H_WAIT: begin
                if (link.rvalid) begin
                    if (cur_kind == STEP_RD_DATA) begin
                        nxt_st.rbyte = link.rdata;
                    end else if (link.rdata != cur_data) begin
                        set_err = 1'b1;
                    end
                    nxt_st.step = st_ff.step + 4'h1;
                    nxt_st.state = H_ISSUE;
                end
            end
        endcase

        // Bus slave: one wait cycle, then the answer
        if ((avs_read || avs_write) && !st_ff.wait_n) begin
            nxt_st.wait_n = 1'b1;
            nxt_st.rdata = 32'h0000_0000;
            if (avs_read && avs_address == HOST_CMD_ADDR) begin
                nxt_st.rdata = st_ff.cmd;
            end else if (avs_read && avs_address == HOST_STAT_ADDR) begin
                nxt_st.rdata[STAT_BUSY_BIT] = (st_ff.state != H_IDLE);
                nxt_st.rdata[STAT_DONE_BIT] = st_ff.done;
                nxt_st.rdata[STAT_ERR_BIT] = st_ff.err;
                nxt_st.rdata[STAT_BYTE_LSB +: 8] = st_ff.rbyte;
            end
        end
        // Writes land on the edge at which the master sees waitrequest low
        if (avs_write && st_ff.wait_n) begin
            // Whole-entry updates are left to software as read-modify-write
            if (avs_address == HOST_CMD_ADDR && st_ff.state == H_IDLE) begin // [R1]
                nxt_st.cmd = avs_writedata;
                nxt_st.state = H_ISSUE;
                nxt_st.done = 1'b0;
            end
            if (avs_address == HOST_STAT_ADDR) begin
                if (avs_writedata[STAT_DONE_BIT]) nxt_st.done = 1'b0;
                if (avs_writedata[STAT_ERR_BIT]) nxt_st.err = 1'b0;
            end
        end
        // Hardware set wins over a software clear in the same cycle
        if (set_done) nxt_st.done = 1'b1;
        if (set_err) nxt_st.err = 1'b1;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff.state <= H_IDLE;
            st_ff.cmd <= 32'h0000_0000;
            st_ff.step <= 4'h0;
            st_ff.rbyte <= 8'h00;
            st_ff.done <= 1'b0;
            st_ff.err <= 1'b0;
            st_ff.wait_n <= 1'b0;
            st_ff.rdata <= 32'h0000_0000;
            st_ff.addr <= 8'h00;
            st_ff.wdata <= 8'h00;
            st_ff.wr <= 1'b0;
            st_ff.rd <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign avs_waitrequest = !st_ff.wait_n;
    assign avs_readdata = st_ff.rdata;
    assign link.addr = st_ff.addr;
    assign link.wdata = st_ff.wdata;
    assign link.wr = st_ff.wr;
    assign link.rd = st_ff.rd;

endmodule

//--- aclri_link_properties.sv
// Checker on the byte link between the host and device ends
`timescale 1ns/1ps
module aclri_link_properties
    import aclri_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Link signals
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    logic [7:0] sel_ff;
    logic [7:0] ofs_ff;
    logic trig_ff;
    logic hit;
    // Shadow of the host's writes, so readback can be judged
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_ff <= SEL_RESET;
            ofs_ff <= OFS_RESET;
            trig_ff <= 1'b0;
        end else if (wr) begin
            if (addr == ACL_SEL_ADDR) sel_ff <= wdata;
            if (addr == ACL_OFS_ADDR) ofs_ff <= wdata;
            trig_ff <= addr == ACL_OFS_ADDR && sel_ff[SEL_DIR_BIT];
        end
    end
    assign hit = rd && addr == ACL_DATA_ADDR && trig_ff;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_rd_answer;
        rd |=> rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read unanswered");
    property p_rvalid_cause;
        rvalid |-> $past(rd);
    endproperty
    a_rvalid_cause: assert property (p_rvalid_cause) else $error("stray rvalid");
    property p_one_op;
        !(wr && rd);
    endproperty
    a_one_op: assert property (p_one_op) else $error("read and write together");
    property p_sel_back;
        rd && addr == ACL_SEL_ADDR |=> rdata == sel_ff;
    endproperty
    a_sel_back: assert property (p_sel_back) else $error("select readback");
    property p_ofs_back;
        rd && addr == ACL_OFS_ADDR |=> rdata == ofs_ff;
    endproperty
    a_ofs_back: assert property (p_ofs_back) else $error("offset readback");
    property p_sel_table;
        wr && addr == ACL_SEL_ADDR |-> wdata[7:5] == SEL_TBL_RULE;
    endproperty
    a_sel_table: assert property (p_sel_table) else $error("table select");
    property p_trig_follow;
        wr && addr == ACL_SEL_ADDR && wdata[SEL_DIR_BIT] |-> ##[1:4] wr && addr == ACL_OFS_ADDR;
    endproperty
    a_trig_follow: assert property (p_trig_follow) else $error("no read trigger");
    property p_rsvd_zero;
        hit && ofs_ff inside {[8'h02:8'h0f]} |=> rdata == 8'h00;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved byte");
    property p_frn_byte;
        hit && ofs_ff == OFS_FRN_BYTE |=> rdata[7:4] == 4'h0;
    endproperty
    a_frn_byte: assert property (p_frn_byte) else $error("first rule byte");
    property p_mode_byte;
        hit && ofs_ff == OFS_MODE_BYTE |=> rdata[7:6] == 2'h0 && rdata[3:0] == 4'h0;
    endproperty
    a_mode_byte: assert property (p_mode_byte) else $error("mode byte");
    property p_ctrl_byte;
        hit && ofs_ff == OFS_CTRL |=> rdata[7] && rdata[6:4] == 3'h0;
    endproperty
    a_ctrl_byte: assert property (p_ctrl_byte) else $error("control byte");
endmodule

//--- testbench.sv
// Self-checking bench joining the host and device ends of the link
`timescale 1ns/1ps
module testbench;
    import aclri_pkg::*;
    typedef struct {
        string name;
        logic [31:0] exp;
        logic [31:0] mask;
    } aclri_note_t;
    logic ref_clk;
    logic rst_n;
    logic [3:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [3:0] lookup_port;
    logic [3:0] lookup_entry;
    logic [3:0] lookup_action_entry;
    aclri_mode_t lookup_mode;
    logic lookup_active;
    logic probe;
    logic [31:0] seed;
    logic [31:0] q;
    logic [31:0] got;
    logic [1:0] md;
    logic [3:0] frn [6];
    logic [7:0] rsv [5] = '{8'h02, 8'h0c, 8'h0d, 8'h0e, 8'h0f};
    int miscompares;
    int check_count;
    aclri_note_t cur;
    aclri_note_t notes[$];
    aclri_link_if link();
    aclri_host i_aclri_host (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(link.host));
    aclri_device i_aclri_device (.ref_clk(ref_clk), .rst_n(rst_n), .link(link.dev),
        .lookup_port(lookup_port), .lookup_entry(lookup_entry),
        .lookup_action_entry(lookup_action_entry), .lookup_mode(lookup_mode),
        .lookup_active(lookup_active));
    aclri_link_properties i_aclri_link_properties (.ref_clk(ref_clk), .rst_n(rst_n),
        .addr(link.addr), .wdata(link.wdata), .wr(link.wr), .rd(link.rd),
        .rdata(link.rdata), .rvalid(link.rvalid));
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
    endfunction
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Request held until waitrequest is sampled low
    task automatic av(input logic r, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] rq);
        avs_address <= a;
        avs_read <= r;
        avs_write <= !r;
        avs_writedata <= d;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge ref_clk);
        end
        rq = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic idle();
        logic [31:0] rq;
        rq = 32'h1;
        while (rq[STAT_BUSY_BIT] !== 1'b0) begin
            av(1'b1, HOST_STAT_ADDR, 32'h0, rq);
        end
    endtask
    task automatic cmd(input logic [3:0] p, input logic r, input logic [3:0] e,
                       input logic [7:0] o, input logic [7:0] b);
        logic [31:0] rq;
        av(1'b0, HOST_CMD_ADDR, {b, o, 4'h0, e, 3'h0, r, p}, rq);
        idle();
    endtask
    // Read one entry byte; status must show done, no error
    task automatic rd_entry(input logic [3:0] p, input logic [3:0] e, input logic [7:0] o,
                            input logic [7:0] x, input logic [7:0] m);
        logic [31:0] rq;
        cmd(p, 1'b1, e, o, 8'h00);
        notes.push_back('{$sformatf("byte %h", o), {16'h0, x, 8'h02}, {16'h0, m, 8'h06}});
        av(1'b1, HOST_STAT_ADDR, 32'h0, rq);
    endtask
    task automatic look(input logic [3:0] p, input logic [3:0] e, input logic [6:0] x);
        lookup_port <= p;
        lookup_entry <= e;
        repeat (2) @(posedge ref_clk);
        notes.push_back('{"lookup", {25'h0, x}, 32'h7f});
        probe <= 1'b1;
        @(posedge ref_clk);
        probe <= 1'b0;
        @(posedge ref_clk);
    endtask
    always @(posedge ref_clk) begin
        if (((avs_read && avs_waitrequest === 1'b0) || probe) && notes.size() > 0) begin
            cur = notes.pop_front();
            got = probe ? {25'h0, lookup_active, lookup_mode, lookup_action_entry} : avs_readdata;
            check_count++;
            if ((got & cur.mask) !== (cur.exp & cur.mask)) begin
                miscompares++;
                $display("MISMATCH %s expected %h seen %h", cur.name, cur.exp & cur.mask,
                         got & cur.mask);
            end
        end
    end
    initial begin
        repeat (30000) @(posedge ref_clk);
        miscompares++;
        final_report();
    end
    initial begin
        rst_n = 1'b0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        lookup_port = 4'h0;
        lookup_entry = 4'h0;
        probe = 1'b0;
        seed = 32'hdbcaaeb4;
        miscompares = 0;
        check_count = 0;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        for (int p = 1; p <= 5; p++) begin
            rd_entry(4'(p), 4'h5, OFS_FRN_BYTE, 8'h00, 8'hff);
            rd_entry(4'(p), 4'h5, OFS_MODE_BYTE, 8'h00, 8'hff);
            rd_entry(4'(p), 4'h5, OFS_BEN_HI, 8'hff, 8'hff);
            rd_entry(4'(p), 4'h5, OFS_BEN_LO, 8'hff, 8'hff);
            rd_entry(4'(p), 4'h5, OFS_CTRL, 8'h85, 8'h8f);
            look(4'(p), 4'h5, 7'h00);
        end
        $display("test reset_values done");
        // Every mode, MODE_OFF twice, upper bits random so ignored bits are exercised
        for (int p = 1; p <= 5; p++) begin
            md = 2'(p - 1);
            frn[p] = seed[3:0];
            cmd(4'(p), 1'b0, 4'(2 * p), OFS_FRN_BYTE, seed[7:0]);
            cmd(4'(p), 1'b0, 4'(2 * p), OFS_MODE_BYTE, {seed[15:14], md, seed[11:8]});
            seed = lfsr(seed);
            rd_entry(4'(p), 4'(2 * p), OFS_FRN_BYTE, {4'h0, frn[p]}, 8'hff);
            rd_entry(4'(p), 4'(2 * p), OFS_MODE_BYTE, {2'h0, md, 4'h0}, 8'hff);
            look(4'(p), 4'(2 * p), {md != 2'h0, md, frn[p]});
            look(4'(p), 4'(2 * p + 1), 7'h00);
        end
        $display("test entry_fields done");
        foreach (rsv[i]) begin
            cmd(4'h3, 1'b0, 4'h6, rsv[i], seed[7:0]);
            seed = lfsr(seed);
            rd_entry(4'h3, 4'h6, rsv[i], 8'h00, 8'hff);
        end
        rd_entry(4'h3, 4'h6, OFS_FRN_BYTE, {4'h0, frn[3]}, 8'hff);
        $display("test reserved_offsets done");
        cmd(4'h4, 1'b0, 4'h8, OFS_BEN_HI, 8'h3f);
        rd_entry(4'h4, 4'h8, OFS_BEN_HI, 8'h3f, 8'hff);
        cmd(4'h4, 1'b0, 4'h8, OFS_FRN_BYTE, {4'h0, ~frn[4]});
        rd_entry(4'h4, 4'h8, OFS_FRN_BYTE, {4'h0, frn[4]}, 8'hff);
        cmd(4'h4, 1'b0, 4'h8, OFS_BEN_HI, 8'hff);
        cmd(4'h4, 1'b0, 4'h8, OFS_FRN_BYTE, {4'h0, ~frn[4]});
        rd_entry(4'h4, 4'h8, OFS_FRN_BYTE, {4'h0, ~frn[4]}, 8'hff);
        $display("test byte_enables done");
        cmd(4'h6, 1'b0, 4'h2, OFS_FRN_BYTE, 8'h0a);
        look(4'h6, 4'h2, 7'h00);
        look(4'h2, 4'h2, 7'h00);
        // Second command lands while busy and must be dropped
        av(1'b0, HOST_CMD_ADDR, {8'h05, OFS_FRN_BYTE, 16'h0102}, q);
        av(1'b0, HOST_CMD_ADDR, {8'h09, OFS_FRN_BYTE, 16'h0102}, q);
        idle();
        rd_entry(4'h2, 4'h1, OFS_FRN_BYTE, 8'h05, 8'hff);
        $display("test refusals done");
        final_report();
    end
endmodule
